/* File: common/dcfpf_pkg.sv */
/*
  Constants and types for the dual-clock port-A-to-port-B FIFO with
  almost-empty and almost-full flags.
  Assumes one system clock samples both port clocks as ordinary inputs.
*/
package dcfpf_pkg;

  // Data path and storage
  localparam int DATA_W = 36;
  localparam int PTR_W  = 12;
  localparam int CNT_W  = 13;
  localparam int DEPTH  = 4096;
  localparam logic [CNT_W-1:0] DEPTH_CNT = 13'h1000;

  // Port B piece counts per long word
  localparam logic [2:0] PIECES_LONG = 3'h1;
  localparam logic [2:0] PIECES_WORD = 3'h2;
  localparam logic [2:0] PIECES_BYTE = 3'h4;
  localparam int WORD_W = 18;
  localparam int BYTE_W = 9;

  // Level of the size input that selects byte width (encoding not fixed)
  localparam logic SIZE_BYTE_LEVEL = 1'b1;

  // Reset values
  localparam logic READY_RST      = 1'b0;
  localparam logic ALMOST_E_N_RST = 1'b0;
  localparam logic ALMOST_F_N_RST = 1'b1;
  localparam logic OE_N_RST       = 1'b1;
  localparam logic SEL_N_RST      = 1'b1;

  // Configuration capture after reset release
  typedef enum logic [1:0] {
    DCFPF_CFG_WAIT0 = 2'b00,
    DCFPF_CFG_WAIT1 = 2'b01,
    DCFPF_CFG_RUN   = 2'b10,
    DCFPF_CFG_WAIT2 = 2'b11
  } dcfpf_cfg_t;

  // Every pin input that crosses into the system clock
  typedef struct packed {
    logic              wclk;
    logic              rclk;
    logic              a_sel_n;
    logic              a_en;
    logic              a_write;
    logic              b_sel_n;
    logic              b_en;
    logic              b_write;
    logic              endian;
    logic              bus_width;
    logic              size;
    logic [PTR_W-1:0]  empty_off;
    logic [PTR_W-1:0]  full_off;
    logic [DATA_W-1:0] a_data;
  } dcfpf_pins_t;

  // Output half of a two-way data pad
  typedef struct packed {
    logic              oe_n;
    logic [DATA_W-1:0] data;
  } dcfpf_pad_t;

  // Whole state of the block
  typedef struct packed {
    dcfpf_pins_t                   meta;
    dcfpf_pins_t                   sync;
    logic                          wclk_prev;
    logic                          rclk_prev;
    dcfpf_cfg_t                    cfg;
    logic                          big_endian;
    logic [DEPTH-1:0][DATA_W-1:0]  mem;
    logic [PTR_W-1:0]              wr_ptr;
    logic [PTR_W-1:0]              rd_ptr;
    logic [CNT_W-1:0]              count;
    logic [DATA_W-1:0]             hold;
    logic [2:0]                    left;
    dcfpf_pad_t                    pad_a;
    dcfpf_pad_t                    pad_b;
    logic                          full_s1;
    logic                          full_s2;
    logic                          afull_s1;
    logic                          afull_s2;
    logic                          empty_s1;
    logic                          empty_s2;
    logic                          aempty_s1;
    logic                          aempty_s2;
  } dcfpf_state_t;

endpackage : dcfpf_pkg

/* File: hw/dcfpf_top.sv */
/*
  Port-A-to-port-B FIFO with bus sizing, endian order, two timing modes
  and programmable almost flags, all on one system clock.
  Every pin, the two port clocks included, is brought in through a
  two-flop synchroniser and the port clocks are edge-detected there, so
  a port transfer is acted on three system clocks after its port clock
  rose. Storage is a flip-flop array of long words indexed by two
  pointers; the stored count decides full and the almost flags; empty comes from the pieces still held, with the stored count added in standard mode.
  Port B hands out a long word in one, two or four pieces; the word
  being handed out leaves the store at its first piece, so the almost
  flags count only what is still queued behind it.
  Endian order is latched once, three clocks after reset release, from
  the synchronised shared pin; afterwards that pin picks the timing mode.
  Port A reads return zero, and port B writes are ignored, as this block
  carries no mailbox.
  A write into a full store and a read from an empty one are dropped
  without any error indication.
  Assumes the port clocks are far slower than clk_in so that each port
  clock edge is seen after the two-flop synchronisers, and that every
  port control is steady around the port clock rise that it qualifies.
*/
`timescale 1ns/100ps
module dcfpf_top (
  input  wire logic                          clk_in,
  input  wire logic                          arst_n_in,
  input  wire logic                          write_port_clock_in,
  input  wire logic                          read_port_clock_in,
  input  wire logic                          write_port_select_n_in,
  input  wire logic                          read_port_select_n_in,
  input  wire logic                          write_port_enable_in,
  input  wire logic                          read_port_enable_in,
  input  wire logic                          port_a_write_in,
  input  wire logic                          port_b_write_in,
  input  wire logic [dcfpf_pkg::DATA_W-1:0]  port_a_data_in,
  input  wire logic [dcfpf_pkg::DATA_W-1:0]  port_b_data_in,
  input  wire logic                          endian_timing_select_in,
  input  wire logic                          bus_width_select_in,
  input  wire logic                          size_in,
  input  wire logic [dcfpf_pkg::PTR_W-1:0]   almost_empty_offset_in,
  input  wire logic [dcfpf_pkg::PTR_W-1:0]   almost_full_offset_in,
  output      dcfpf_pkg::dcfpf_pad_t         port_a_pad_out,
  output      dcfpf_pkg::dcfpf_pad_t         port_b_pad_out,
  output      logic                          empty_outready_flag_out,
  output      logic                          full_inready_flag_out,
  output      logic                          almost_empty_flag_n_out,
  output      logic                          almost_full_flag_n_out
);
  import dcfpf_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Piece of a long word as seen on port B, right-aligned
  // Index counts pieces in delivery order; big flips it so that the
  // most significant piece leaves first, little keeps bit order
  // Long word width passes the word through untouched
  function automatic logic [DATA_W-1:0] dcfpf_piece(
    input logic [DATA_W-1:0] word,
    input logic [2:0]        pieces,
    input logic [1:0]        idx,
    input logic              big
  );
    logic [1:0] pos;
    pos = 2'h0;
    case (pieces)
      PIECES_WORD: begin
        pos = {1'b0, idx[0] ^ big};
        return {{(DATA_W-WORD_W){1'b0}}, word[WORD_W*pos[0] +: WORD_W]};
      end
      PIECES_BYTE: begin
        pos = big ? (2'h3 - idx) : idx;
        return {{(DATA_W-BYTE_W){1'b0}}, word[BYTE_W*pos +: BYTE_W]};
      end
      default: return word;
    endcase
  endfunction : dcfpf_piece

  //////////////////////////////////////////////////////////////////////////////
  dcfpf_state_t st_q;
  dcfpf_state_t st_d;
  dcfpf_pins_t  pins;

  // Bundle of raw pin inputs
  // Gathered in one struct so that one register stage carries them all
  always_comb begin
    pins.wclk      = write_port_clock_in;
    pins.rclk      = read_port_clock_in;
    pins.a_sel_n   = write_port_select_n_in;
    pins.a_en      = write_port_enable_in;
    pins.a_write   = port_a_write_in;
    pins.b_sel_n   = read_port_select_n_in;
    pins.b_en      = read_port_enable_in;
    pins.b_write   = port_b_write_in;
    pins.endian    = endian_timing_select_in;
    pins.bus_width = bus_width_select_in;
    pins.size      = size_in;
    pins.empty_off = almost_empty_offset_in;
    pins.full_off  = almost_full_offset_in;
    pins.a_data    = port_a_data_in;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  // One copy of the state is edited here and registered below
  always_comb begin
    logic             a_edge;
    logic             b_edge;
    logic             a_acc;
    logic             b_acc;
    logic             run;
    logic             fwft;
    logic             wr;
    logic             pop;
    logic [2:0]       pieces;
    logic [CNT_W-1:0] free;
    a_edge = 1'b0;
    b_edge = 1'b0;
    a_acc  = 1'b0;
    b_acc  = 1'b0;
    run    = 1'b0;
    fwft   = 1'b0;
    wr     = 1'b0;
    pop    = 1'b0;
    pieces = PIECES_LONG;
    free   = '0;
    st_d   = st_q;

    // Two-flop synchronisers; first stage feeds only the second
    // Nothing but the second stage reads the first, so a metastable
    // first stage never reaches the datapath
    st_d.meta      = pins;
    st_d.sync      = st_q.meta;
    st_d.wclk_prev = st_q.sync.wclk;
    st_d.rclk_prev = st_q.sync.rclk;

    // Endian caught once the synchronised pin is valid after release
    // The second stage holds its reset value for two clocks after
    // release, so the pin is latched only at the third clock
    case (st_q.cfg)
      DCFPF_CFG_WAIT0: st_d.cfg = DCFPF_CFG_WAIT1;
      DCFPF_CFG_WAIT1: st_d.cfg = DCFPF_CFG_WAIT2;
      DCFPF_CFG_WAIT2: begin
        st_d.big_endian = st_q.sync.endian;
        st_d.cfg        = DCFPF_CFG_RUN;
      end
      DCFPF_CFG_RUN:   st_d.cfg = DCFPF_CFG_RUN;
      default:         st_d.cfg = DCFPF_CFG_WAIT0;
    endcase
    run  = (st_q.cfg == DCFPF_CFG_RUN);
    fwft = ~st_q.sync.endian;

    // Port clock rising edges gated by select and enable
    // No transfer is taken until the endian latch has settled
    a_edge = st_q.sync.wclk & ~st_q.wclk_prev;
    b_edge = st_q.sync.rclk & ~st_q.rclk_prev;
    a_acc  = run & a_edge & ~st_q.sync.a_sel_n & st_q.sync.a_en;
    b_acc  = run & b_edge & ~st_q.sync.b_sel_n & st_q.sync.b_en;

    // Port B width from bus-width select and size
    // Long word pass-through whenever bus-width select is low
    if (st_q.sync.bus_width) begin
      pieces = (st_q.sync.size == SIZE_BYTE_LEVEL) ? PIECES_BYTE : PIECES_WORD;
    end

    // Port A write into storage, refused while full
    // A full store drops the word rather than overwrite the oldest
    wr = a_acc & st_q.sync.a_write & (st_q.count != DEPTH_CNT);
    if (wr) begin
      st_d.mem[st_q.wr_ptr] = st_q.sync.a_data;
      st_d.wr_ptr           = st_q.wr_ptr + PTR_W'(1);
    end

    // Port B read path
    // Standard mode: each read shows the next piece, or takes the head
    // long word from the store once the held one is used up
    if (!fwft) begin
      if (b_acc && !st_q.sync.b_write) begin
        if (st_q.left != 3'h0) begin
          st_d.pad_b.data = dcfpf_piece(st_q.hold, pieces, 2'(pieces - st_q.left),
                                        st_q.big_endian);
          st_d.left       = st_q.left - 3'h1;
        end else if (st_q.count != '0) begin
          pop             = 1'b1;
          st_d.hold       = st_q.mem[st_q.rd_ptr];
          st_d.pad_b.data = dcfpf_piece(st_q.mem[st_q.rd_ptr], pieces, 2'h0,
                                        st_q.big_endian);
          st_d.left       = pieces - 3'h1;
        end
      end
    end else begin
      if (b_acc && !st_q.sync.b_write && st_q.left != 3'h0) begin
        st_d.left = st_q.left - 3'h1;
      end
      // Next long word falls through once the last piece is taken
      // The head word appears without a read, so the flag means valid data
      if (run && st_d.left == 3'h0 && st_q.count != '0) begin
        pop       = 1'b1;
        st_d.hold = st_q.mem[st_q.rd_ptr];
        st_d.left = pieces;
      end
      if (st_d.left != 3'h0) begin
        st_d.pad_b.data = dcfpf_piece(st_d.hold, pieces, 2'(pieces - st_d.left),
                                      st_q.big_endian);
      end
    end
    // Read pointer and count follow the pop; write and pop may share a clock
    if (pop) begin
      st_d.rd_ptr = st_q.rd_ptr + PTR_W'(1);
    end
    st_d.count = st_q.count + CNT_W'(wr) - CNT_W'(pop);
    // Free locations for the almost-full compare, from the old count
    free       = DEPTH_CNT - st_q.count;

    // Port A flags, two stages advanced on A edges only
    // Sampled from the live count and shifted once more, so each flag
    // lags by two port A rises and never moves between them
    // Ready high means space is left, low a full store; almost-full low means free space at or below the offset
    if (a_edge) begin
      st_d.full_s1  = (st_q.count != DEPTH_CNT);
      st_d.full_s2  = st_q.full_s1;
      st_d.afull_s1 = ~(free <= CNT_W'(st_q.sync.full_off));
      st_d.afull_s2 = st_q.afull_s1;
    end

    // Port B flags, two stages advanced on B edges only
    // Same two-rise lag in the port B domain; high means readable
    if (b_edge) begin
      st_d.empty_s1  = fwft ? (st_q.left != 3'h0)
                            : (st_q.count != '0 || st_q.left != 3'h0);
      st_d.empty_s2  = st_q.empty_s1;
      st_d.aempty_s1 = ~(st_q.count <= CNT_W'(st_q.sync.empty_off));
      st_d.aempty_s2 = st_q.aempty_s1;
    end

    // Pad drivers on only for a selected read
    // Decided from synchronised pins, so drivers turn on or off three
    // clocks after the select moves
    st_d.pad_a.oe_n = st_q.sync.a_sel_n | st_q.sync.a_write;
    st_d.pad_a.data = '0;
    st_d.pad_b.oe_n = st_q.sync.b_sel_n | st_q.sync.b_write;
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register
  // Synchronised selects reset to the deselected level so that no
  // pad is driven in the clocks before the pins have propagated
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_q            <= '0;
      st_q.cfg        <= DCFPF_CFG_WAIT0;
      st_q.pad_a.oe_n <= OE_N_RST;
      st_q.pad_b.oe_n <= OE_N_RST;
      st_q.meta.a_sel_n <= SEL_N_RST;
      st_q.sync.a_sel_n <= SEL_N_RST;
      st_q.meta.b_sel_n <= SEL_N_RST;
      st_q.sync.b_sel_n <= SEL_N_RST;
      st_q.full_s1    <= READY_RST;
      st_q.full_s2    <= READY_RST;
      st_q.empty_s1   <= READY_RST;
      st_q.empty_s2   <= READY_RST;
      st_q.afull_s1   <= ALMOST_F_N_RST;
      st_q.afull_s2   <= ALMOST_F_N_RST;
      st_q.aempty_s1  <= ALMOST_E_N_RST;
      st_q.aempty_s2  <= ALMOST_E_N_RST;
    end else begin
      st_q <= st_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state
  // All outputs leave flip-flops; none is decoded on the way out
  assign port_a_pad_out          = st_q.pad_a;
  assign port_b_pad_out          = st_q.pad_b;
  assign empty_outready_flag_out = st_q.empty_s2;
  assign full_inready_flag_out   = st_q.full_s2;
  assign almost_empty_flag_n_out = st_q.aempty_s2;
  assign almost_full_flag_n_out  = st_q.afull_s2;

endmodule : dcfpf_top

/* File: tb/dcfpf_host_clk.sv */
/*
  Host-side clock source for both FIFO ports.
  Assumes clk_in at 100 ns; run_in starts both clocks after reset.
*/
`timescale 1ns/100ps
module dcfpf_host_clk (
  input  wire logic run_in,
  input  wire logic clk_in,
  output      logic wclk_out,
  output      logic rclk_out
);
  logic [2:0] cnt_q;
  logic       b_on_q;

  // Free-running 800 ns clocks, port B half a period behind port A
  always @(posedge clk_in) begin
    cnt_q  <= #10 run_in ? cnt_q + 3'h1 : 3'h0;
    b_on_q <= #10 run_in && (b_on_q || cnt_q == 3'h7);
  end
  assign wclk_out = cnt_q[2];
  assign rclk_out = b_on_q & ~cnt_q[2];
endmodule : dcfpf_host_clk

/* File: tb/dcfpf_checker.sv */
/*
  Pad and flag timing checks for the FIFO top.
  Assumes port clocks far slower than clk_in; bound from the bench top.
*/
`timescale 1ns/100ps
module dcfpf_checker (
  input wire logic                clk_in,
  input wire logic                arst_n_in,
  input wire logic                write_port_clock_in,
  input wire logic                read_port_clock_in,
  input wire logic                write_port_select_n_in,
  input wire logic                read_port_select_n_in,
  input wire logic                port_a_write_in,
  input wire dcfpf_pkg::dcfpf_pad_t port_a_pad_out,
  input wire dcfpf_pkg::dcfpf_pad_t port_b_pad_out,
  input wire logic                empty_outready_flag_out,
  input wire logic                full_inready_flag_out,
  input wire logic                almost_empty_flag_n_out,
  input wire logic                almost_full_flag_n_out
);
  import dcfpf_pkg::*;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  ////////////////////////////////////////////////////////////
  // Flags move only just after their own port clock rose
  aflag_edge_a:
    assert property ($changed({full_inready_flag_out, almost_full_flag_n_out})
      |-> $past(write_port_clock_in, 3)) else $error("Port A flag moved off an A rise");
  bflag_edge_a:
    assert property ($changed({empty_outready_flag_out, almost_empty_flag_n_out})
      |-> $past(read_port_clock_in, 3)) else $error("Port B flag moved off a B rise");
  // Drivers off once select has been high for a while
  aoff_sel_a:
    assert property (write_port_select_n_in [*5] |-> port_a_pad_out.oe_n)
      else $error("Port A driven while deselected");
  boff_sel_a:
    assert property (read_port_select_n_in [*5] |-> port_b_pad_out.oe_n)
      else $error("Port B driven while deselected");
  // Drivers turn on only when selected, and on port A only for a read
  aon_read_a:
    assert property ($fell(port_a_pad_out.oe_n) |-> !$past(write_port_select_n_in, 3)
      && !$past(port_a_write_in, 3)) else $error("Port A driven without a read");
  bon_sel_a:
    assert property ($fell(port_b_pad_out.oe_n) |-> !$past(read_port_select_n_in, 3))
      else $error("Port B driven without select");
  adata_zero_a:
    assert property (!port_a_pad_out.oe_n |-> port_a_pad_out.data == 36'h000000000)
      else $error("Port A read data not zero");
  // Above the empty offset there must be readable data
  aempty_ready_a:
    assert property (almost_empty_flag_n_out |-> empty_outready_flag_out)
      else $error("Almost-empty high while not ready");
endmodule : dcfpf_checker

/* File: tb/dcfpf_top_tb_top.sv */
/*
  Self-checking bench: word, byte and long paths, both endian orders,
  both timing modes, select gating and almost flags.
  Assumes the host clock model and the checker bound below.
*/
`timescale 1ns/100ps
module dcfpf_top_tb_top;
  import dcfpf_pkg::*;
  typedef struct packed {
    logic [DATA_W-1:0] word;
    logic [WORD_W-1:0] first;
    logic [WORD_W-1:0] second;
  } dcfpf_row_t;
  dcfpf_row_t rows [2] = '{'{{18'h31234, 18'h05678}, 18'h31234, 18'h05678},
                           '{{18'h2AAAA, 18'h15555}, 18'h2AAAA, 18'h15555}};
  logic [8:0] bl [4] = '{9'h111, 9'h07E, 9'h0C3, 9'h1A5};
  logic clk_in = 1'b0, arst_n = 1'b0, run = 1'b0, aclk, bclk;
  logic sel_a_n = 1'b0, sel_b_n = 1'b0, en_a = 1'b0, en_b = 1'b0, wr_a = 1'b1;
  logic ets = 1'b1, bws = 1'b1, sz = 1'b0, ef, ff, ae_n, af_n;
  logic [DATA_W-1:0] a_data = 36'h000000000;
  dcfpf_pad_t pad_a, pad_b;
  int bad_count = 0, checks_done = 0, cyc = 0;

  always #50 clk_in = ~clk_in;
  dcfpf_host_clk host (.run_in(run), .clk_in(clk_in), .wclk_out(aclk), .rclk_out(bclk));
  dcfpf_top DUT (.clk_in(clk_in), .arst_n_in(arst_n), .write_port_clock_in(aclk),
    .read_port_clock_in(bclk), .write_port_select_n_in(sel_a_n),
    .read_port_select_n_in(sel_b_n), .write_port_enable_in(en_a),
    .read_port_enable_in(en_b), .port_a_write_in(wr_a), .port_b_write_in(1'b0),
    .port_a_data_in(a_data), .port_b_data_in(36'h000000000), .endian_timing_select_in(ets),
    .bus_width_select_in(bws), .size_in(sz), .almost_empty_offset_in(12'h001),
    .almost_full_offset_in(12'hFFE), .port_a_pad_out(pad_a), .port_b_pad_out(pad_b),
    .empty_outready_flag_out(ef), .full_inready_flag_out(ff),
    .almost_empty_flag_n_out(ae_n), .almost_full_flag_n_out(af_n));
  ////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  // Hang guard
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 4000) begin
      bad_count++;
      $display("MISMATCH at %0t: run too long", $time);
      report_and_stop();
    end
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #10;
  endtask : step

  task automatic chk(input logic [DATA_W-1:0] got, exp, input string m);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: %s", $time, m);
    end
  endtask : chk

  // Reset with endian level, then timing level held static
  task automatic restart(input logic e, t, b, s);
    arst_n = 1'b0;
    run = 1'b0;
    ets = e;
    bws = b;
    sz = s;
    step(4);
    arst_n = 1'b1;
    step(3);
    ets = t;
    step(3);
    run = 1'b1;
  endtask : restart

  // One port A write over one A clock rise
  task automatic put(input logic [DATA_W-1:0] w, input logic s_n, e);
    @(negedge aclk);
    sel_a_n = s_n;
    en_a = e;
    a_data = w;
    @(negedge aclk);
    sel_a_n = 1'b0;
    en_a = 1'b0;
  endtask : put

  // One port B read over one B clock rise
  task automatic take();
    @(negedge bclk);
    en_b = 1'b1;
    @(negedge bclk);
    en_b = 1'b0;
    step(1);
  endtask : take

  task automatic wait_ready();
    for (int i = 0; i < 80 && ef !== 1'b1; i++) step(1);
    chk(ef, 1'b1, "ready flag stayed low");
  endtask : wait_ready

  initial begin
    restart(1'b1, 1'b1, 1'b1, 1'b0);
    chk(ef, READY_RST, "empty flag reset");
    chk(ff, READY_RST, "full flag reset");
    chk(ae_n, ALMOST_E_N_RST, "almost-empty reset");
    chk(af_n, ALMOST_F_N_RST, "almost-full reset");
    $display("test reset done");
    foreach (rows[i]) begin
      put(rows[i].word, 1'b0, 1'b1);
      wait_ready();
      take();
      chk(pad_b.data & 36'h00003FFFF, rows[i].first, "first word piece");
      take();
      chk(pad_b.data & 36'h00003FFFF, rows[i].second, "second word piece");
    end
    $display("test rows done");
    put(36'h000000001, 1'b0, 1'b1);
    put(36'h000000002, 1'b0, 1'b1);
    step(40);
    chk(ae_n, 1'b1, "almost-empty above offset");
    chk(af_n, 1'b0, "almost-full at offset");
    chk(ff, 1'b1, "space flag");
    take();
    take();
    step(40);
    chk(ae_n, 1'b0, "almost-empty at offset");
    chk(af_n, 1'b1, "almost-full above offset");
    $display("test almost flags done");
    sel_a_n = 1'b1;
    sel_b_n = 1'b1;
    step(6);
    chk(pad_a.oe_n, 1'b1, "port A not released");
    chk(pad_b.oe_n, 1'b1, "port B not released");
    take();
    sel_a_n = 1'b0;
    sel_b_n = 1'b0;
    wr_a = 1'b0;
    step(6);
    chk(pad_a.oe_n, 1'b0, "port A not driven on read");
    chk(pad_a.data, 36'h000000000, "port A read data");
    chk(pad_b.oe_n, 1'b0, "port B not driven");
    wr_a = 1'b1;
    take();
    chk(pad_b.data & 36'h00003FFFF, 36'h000000000, "deselected read taken");
    take();
    chk(pad_b.data & 36'h00003FFFF, 36'h000000002, "low piece");
    $display("test select done");
    restart(1'b0, 1'b0, 1'b1, SIZE_BYTE_LEVEL);
    put({bl[3], bl[2], bl[1], bl[0]}, 1'b0, 1'b1);
    wait_ready();
    for (int k = 0; k < 4; k++) begin
      if (k > 0) take();
      chk(pad_b.data & 36'h0000001FF, {27'h0, bl[k]}, "byte order");
    end
    take();
    put(36'h000000005, 1'b1, 1'b1);
    put(36'h000000006, 1'b0, 1'b0);
    step(40);
    chk(ef, 1'b0, "gated write landed");
    $display("test fall-through done");
    restart(1'b1, 1'b1, 1'b0, 1'b0);
    put(36'h987654321, 1'b0, 1'b1);
    wait_ready();
    take();
    chk(pad_b.data, 36'h987654321, "long word");
    $display("test long word done");
    report_and_stop();
  end
endmodule : dcfpf_top_tb_top

bind dcfpf_top dcfpf_checker chk_u (.clk_in(clk_in), .arst_n_in(arst_n_in),
  .write_port_clock_in(write_port_clock_in), .read_port_clock_in(read_port_clock_in),
  .write_port_select_n_in(write_port_select_n_in), .port_a_write_in(port_a_write_in),
  .read_port_select_n_in(read_port_select_n_in), .port_a_pad_out(port_a_pad_out),
  .port_b_pad_out(port_b_pad_out), .empty_outready_flag_out(empty_outready_flag_out),
  .full_inready_flag_out(full_inready_flag_out),
  .almost_empty_flag_n_out(almost_empty_flag_n_out),
  .almost_full_flag_n_out(almost_full_flag_n_out));
